// ---- hsp_defines.svh ----
// Constants for the halt and clock-stop power mode controller
`ifndef HSP_DEFINES_SVH
`define HSP_DEFINES_SVH
`define HSP_STAB_W      16
`define HSP_PC_W        14
`define HSP_PIN_W       48
`define HSP_ADC_PINS_W  6
`endif

// ---- hsp_pkg.sv ----
// Types for the halt and clock-stop power mode controller
package hsp_pkg;
  typedef enum logic [1:0] {
    HSP_RUN    = 2'b00,
    HSP_HALT   = 2'b01,
    HSP_STOP   = 2'b10,
    HSP_SETTLE = 2'b11
  } hsp_mode_e;
endpackage

// ---- hsp_settle_timer.sv ----
// Half stabilization wait counter used after clock-stop release
`timescale 1ns/1ps
`include "hsp_defines.svh"
module hsp_settle_timer #(
  parameter int W = `HSP_STAB_W
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         start,     // Load pulse
  input  wire logic [W-1:0] full_time, // Configured stabilization time in cycles
  output logic              done       // High for one cycle at expiry
);
  typedef struct packed
  {
    logic [W-1:0] cnt;
    logic         busy;
    logic         done;
  } hsp_tmr_s;
  hsp_tmr_s st;
  hsp_tmr_s next_st;

  // Count down half of the configured time, at least one cycle
  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    if (start)
    begin
      next_st.cnt  = (full_time >> 1) == '0 ? W'(1) : (full_time >> 1);
      next_st.busy = 1'b1;
    end
    else if (st.busy)
    begin
      if (st.cnt == W'(1))
      begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
      next_st.cnt = st.cnt - W'(1);
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign done = st.done;
endmodule

// ---- hsp_pin_hold.sv ----
// Pin mode override: forces general port mode in stop, retaining direction and level
`timescale 1ns/1ps
`include "hsp_defines.svh"
module hsp_pin_hold #(
  parameter int W = `HSP_PIN_W
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         stop_enter, // Capture moment
  input  wire logic         stopped,    // Override active
  input  wire logic [W-1:0] keep_mask,  // Pins exempt from forcing
  input  wire logic [W-1:0] alt_sel,    // Peripheral function selects
  input  wire logic [W-1:0] dir_out,    // Configured directions
  input  wire logic [W-1:0] out_val,    // Current output levels
  output logic      [W-1:0] alt_sel_o,
  output logic      [W-1:0] dir_out_o,
  output logic      [W-1:0] out_val_o
);
  typedef struct packed
  {
    logic [W-1:0] alt;
    logic [W-1:0] dir;
    logic [W-1:0] val;
  } hsp_pin_s;
  hsp_pin_s st;
  hsp_pin_s next_st;

  // Snapshot at stop entry; hold while stopped or settling; pass through otherwise (halt keeps pins unchanged)
  always_comb
  begin
    next_st = st;
    if (stop_enter)
    begin
      next_st.alt = alt_sel & keep_mask;
      next_st.dir = dir_out;
      next_st.val = out_val;
    end
    else if (!stopped)
    begin
      next_st.alt = alt_sel;
      next_st.dir = dir_out;
      next_st.val = out_val;
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign alt_sel_o = st.alt;
  assign dir_out_o = st.dir;
  assign out_val_o = st.val;
endmodule

// ---- hsp_power_ctrl.sv ----
// Halt and clock-stop power mode controller top
`timescale 1ns/1ps
`include "hsp_defines.svh"
module hsp_power_ctrl #(
  parameter int PW = `HSP_PIN_W,
  parameter int CW = `HSP_PC_W,
  parameter int TW = `HSP_STAB_W,
  parameter int AW = `HSP_ADC_PINS_W
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          halt_req,        // Halt instruction strobe
  input  wire logic          stop_req,        // Clock-stop instruction strobe
  input  wire logic          halt_release,    // Halt release condition met
  input  wire logic          stop_release,    // Stop release condition met
  input  wire logic [CW-1:0] pc_in,           // Address of current instruction
  input  wire logic          chip_en,         // Chip-enable pin level
  input  wire logic          ce_rise,         // Chip-enable rising seen
  input  wire logic          ce_cnt_busy,     // Chip-enable reset counter running
  input  wire logic [TW-1:0] stab_time,       // Stabilization time in cycles
  input  wire logic          sio_ext_clk,     // Serial clocked externally (slave)
  input  wire logic          pll_sw_en,       // Software synthesizer enable
  input  wire logic [3:0]    analog_pd_en,    // Analog port pull-down selects
  input  wire logic [PW-1:0] keep_mask,       // Pins exempt from forcing
  input  wire logic [PW-1:0] alt_sel,         // Peripheral function selects
  input  wire logic [PW-1:0] dir_out,         // Configured directions
  input  wire logic [PW-1:0] out_val,         // Configured output levels
  output logic               cpu_run,         // Instruction execution enable
  output logic [CW-1:0]      pc_hold,         // Frozen program counter
  output logic               osc_run,         // Oscillator enable
  output logic               timer_run,
  output logic               pll_run,
  output logic               adc_run,
  output logic               pwm_run,
  output logic               sio_run,
  output logic               fcnt_run,
  output logic               tone_run,
  output logic               ctrl_init,       // One-cycle control register default load
  output logic [3:0]         analog_pd_o,     // Pull-down enables to pads
  output logic [PW-1:0]      pin_alt_o,
  output logic [PW-1:0]      pin_dir_o,
  output logic [PW-1:0]      pin_val_o
);
  typedef struct packed
  {
    hsp_pkg::hsp_mode_e mode;
    logic [CW-1:0]      pc;
    logic               init;
    logic [3:0]         pd;
  } hsp_top_s;
  hsp_top_s st;
  hsp_top_s next_st;

  logic stop_ok;     // Stop accepted (not a no-op)
  logic stop_enter;  // Stop taken this cycle, last cycle of run
  logic settle_done; // Half stabilization elapsed
  logic stopped;     // Override window for pins

  // Stop behaves as no-op while chip-enable reset activity runs
  assign stop_ok    = stop_req && !ce_rise && !ce_cnt_busy;
  assign stop_enter = (st.mode == hsp_pkg::HSP_RUN) && stop_ok;
  assign stopped    = (st.mode == hsp_pkg::HSP_STOP) || (st.mode == hsp_pkg::HSP_SETTLE);

  // Mode sequencing
  always_comb
  begin
    next_st = st;
    next_st.init = 1'b0;
    // Pull-down selects follow software except while stopped
    if (!stopped && !stop_enter)
      next_st.pd = analog_pd_en;
    unique case (st.mode)
      hsp_pkg::HSP_RUN:
      begin
        if (stop_enter)
        begin
          next_st.mode = hsp_pkg::HSP_STOP;
          next_st.pc   = pc_in;
          next_st.init = 1'b1;
          next_st.pd   = analog_pd_en;
        end
        else if (halt_req)
        begin
          next_st.mode = hsp_pkg::HSP_HALT;
          next_st.pc   = pc_in;
        end
      end
      hsp_pkg::HSP_HALT:
      begin
        // Halt release returns straight to execution
        if (halt_release)
          next_st.mode = hsp_pkg::HSP_RUN;
      end
      hsp_pkg::HSP_STOP:
      begin
        if (stop_release)
          next_st.mode = hsp_pkg::HSP_SETTLE;
      end
      hsp_pkg::HSP_SETTLE:
      begin
        // Oscillator runs but execution waits for it to settle
        if (settle_done)
          next_st.mode = hsp_pkg::HSP_RUN;
      end
    endcase
  end

  // State register; system registers live elsewhere and are never touched here
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st.mode <= hsp_pkg::HSP_RUN;
      st.pc   <= '0;
      st.init <= 1'b0;
      st.pd   <= 4'h0;
    end
    else
      st <= next_st;
  end

  // Settle wait starts as the release is taken
  hsp_settle_timer #(
    .W (TW)
  ) u_settle (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .start     ((st.mode == hsp_pkg::HSP_STOP) && stop_release),
    .full_time (stab_time),
    .done      (settle_done)
  );

  // Pin override: upper interrupt and analog pins are in keep_mask
  hsp_pin_hold #(
    .W (PW)
  ) u_pins (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .stop_enter (stop_enter),
    .stopped    (stopped),
    .keep_mask  (keep_mask),
    .alt_sel    (alt_sel),
    .dir_out    (dir_out),
    .out_val    (out_val),
    .alt_sel_o  (pin_alt_o),
    .dir_out_o  (pin_dir_o),
    .out_val_o  (pin_val_o)
  );

  // Peripheral run enables: all run in run and halt except master serial in halt, none in stop or settle
  logic periph_on;
  assign periph_on = (st.mode == hsp_pkg::HSP_RUN) || (st.mode == hsp_pkg::HSP_HALT);
  assign cpu_run   = (st.mode == hsp_pkg::HSP_RUN);
  assign pc_hold   = st.pc;
  assign osc_run   = (st.mode != hsp_pkg::HSP_STOP);
  assign timer_run = periph_on;
  assign adc_run   = periph_on;
  // Synthesizer needs chip-enable high in every mode
  assign pll_run   = periph_on && chip_en && pll_sw_en;
  assign pwm_run   = periph_on;
  assign fcnt_run  = periph_on;
  assign tone_run  = periph_on;
  // Master serial stops in halt as its shift clock source is gated
  assign sio_run   = (st.mode == hsp_pkg::HSP_RUN) ||
                     ((st.mode == hsp_pkg::HSP_HALT) && sio_ext_clk);
  assign ctrl_init   = st.init;
  assign analog_pd_o = st.pd;
endmodule

// ---- hsp_power_ctrl_properties.sv ----
// Assertions on mode changes, run enables and pin holding of the power controller
`timescale 1ns/1ps
module hsp_power_ctrl_checker #(
  parameter int PW = 48,
  parameter int CW = 14
) (
  input wire logic          ref_clk,
  input wire logic          rst,
  input wire logic          halt_req,
  input wire logic          stop_req,
  input wire logic          halt_release,
  input wire logic          stop_release,
  input wire logic [CW-1:0] pc_in,
  input wire logic          chip_en,
  input wire logic          ce_rise,
  input wire logic          ce_cnt_busy,
  input wire logic          sio_ext_clk,
  input wire logic [PW-1:0] keep_mask,
  input wire logic [PW-1:0] alt_sel,
  input wire logic [PW-1:0] out_val,
  input wire logic          cpu_run,
  input wire logic [CW-1:0] pc_hold,
  input wire logic          osc_run,
  input wire logic          timer_run,
  input wire logic          pll_run,
  input wire logic          adc_run,
  input wire logic          pwm_run,
  input wire logic          sio_run,
  input wire logic          fcnt_run,
  input wire logic          tone_run,
  input wire logic          ctrl_init,
  input wire logic [PW-1:0] pin_alt_o,
  input wire logic [PW-1:0] pin_val_o
);
  // One clock domain, so clocking and reset are declared once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Halt is recognised as timer_run high with cpu_run low; settle has both low
  AST_STOP_IN: assert property (stop_req && cpu_run && !ce_rise && !ce_cnt_busy |=>
    ctrl_init && !osc_run && pc_hold == $past(pc_in)
    && pin_alt_o == ($past(alt_sel) & $past(keep_mask))) else $error("stop entry wrong");
  AST_STOP_NOP: assert property (stop_req && cpu_run && (ce_rise || ce_cnt_busy) |=>
    osc_run && !ctrl_init) else $error("stop not ignored");
  AST_HALT_IN: assert property (halt_req && !stop_req && cpu_run |=>
    !cpu_run && timer_run && adc_run && tone_run && pc_hold == $past(pc_in)) else $error("halt entry");
  AST_HALT_OUT: assert property (!cpu_run && timer_run |=> cpu_run == $past(halt_release))
    else $error("halt exit");
  AST_ALL_OFF: assert property (!osc_run |-> !(cpu_run | timer_run | pll_run | adc_run
    | pwm_run | sio_run | fcnt_run | tone_run)) else $error("unit running in stop");
  AST_PLL_CE: assert property (!chip_en |-> !pll_run) else $error("synth on with enable low");
  AST_SIO: assert property (!cpu_run && timer_run |-> sio_run == sio_ext_clk)
    else $error("serial in halt");
  AST_FROZEN: assert property (!osc_run && !$past(osc_run) |-> $stable(pin_val_o)
    && $stable(pin_alt_o)) else $error("pins moved in stop");
  AST_FOLLOW: assert property (timer_run && $past(timer_run) && !$past(rst) |->
    pin_val_o == $past(out_val)) else $error("pins not following");
  AST_INIT_ONE: assert property (ctrl_init |=> !ctrl_init) else $error("init pulse long");
  AST_SETTLE: assert property (!osc_run && stop_release |=>
    (osc_run && !cpu_run) ##[1:40] cpu_run) else $error("settle wait");
endmodule
bind hsp_power_ctrl hsp_power_ctrl_checker #(.PW(PW), .CW(CW)) u_chk (.*);

// ---- hsp_power_ctrl_tb.sv ----
// Random and corner-case bench for the power mode controller
`timescale 1ns/1ps
module hsp_power_ctrl_tb;
  logic ref_clk, rst, halt_req, stop_req, halt_release, stop_release, ce_rise, ce_cnt_busy;
  logic chip_en, sio_ext_clk, pll_sw_en, cpu_run, osc_run, timer_run, pll_run, adc_run;
  logic pwm_run, sio_run, fcnt_run, tone_run, ctrl_init;
  logic [13:0] pc_in, pc_hold, pcv;
  logic [15:0] stab_time;
  logic [3:0]  analog_pd_en, analog_pd_o, pd;
  logic [47:0] keep_mask, alt_sel, dir_out, out_val, pin_alt_o, pin_dir_o, pin_val_o, v, d, a;
  integer seed = 85;
  int errors = 0, tests_run = 0, cyc = 0, k;
  hsp_power_ctrl dut (.*);
  // Free-running 10 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Inputs move 5 ns after the edge so no race with the design
  task automatic step();
    @(posedge ref_clk);
    #5;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Settle length: half the stabilization time, never below one cycle
  function automatic int settle_n(input logic [15:0] t);
    return (t >> 1) == 16'h0 ? 1 : int'(t >> 1);
  endfunction
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic rnd();
    pc_in = 14'($random(seed));
    out_val = {16'($random(seed)), 32'($random(seed))};
    dir_out = {16'($random(seed)), 32'($random(seed))};
    alt_sel = {16'($random(seed)), 32'($random(seed))};
    keep_mask = {16'($random(seed)), 32'($random(seed))};
    {chip_en, pll_sw_en, sio_ext_clk} = 3'($random(seed));
    analog_pd_en = 4'($random(seed));
  endtask
  // Hang guard: a run of 30 tests needs far fewer cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      errors++;
      end_sim();
    end
  end
  initial
  begin
    {rst, halt_req, stop_req, halt_release, stop_release, ce_rise, ce_cnt_busy} = 7'h40;
    stab_time = 16'h0;
    rnd();
    repeat (20) step();
    rst = 1'b0;
    for (int i = 0; i < 30; i++)
    begin
      rnd();
      stab_time = (i == 1) ? 16'h0 : 16'($random(seed)) & 16'h003F;
      step();
      chk(pin_val_o, out_val);
      chk(pin_dir_o, dir_out);
      chk(48'(analog_pd_o), 48'(analog_pd_en));
      if (i % 3 == 0)
      begin
        pcv = pc_in;
        halt_req = 1'b1;
        step();
        halt_req = 1'b0;
        chk(48'({cpu_run, osc_run, timer_run, adc_run, pwm_run, fcnt_run, tone_run}), 48'h3F);
        chk(48'({pll_run, sio_run}), 48'({chip_en & pll_sw_en, sio_ext_clk}));
        out_val = ~out_val;
        pc_in = ~pc_in;
        step();
        chk(pin_val_o, out_val);
        chk(48'(pc_hold), 48'(pcv));
        halt_release = 1'b1;
        step();
        halt_release = 1'b0;
        chk(48'(cpu_run), 48'h1);
      end
      else if (i % 3 == 1)
      begin
        // Stop entry, with a simultaneous halt request once to show priority
        v = out_val;
        d = dir_out;
        a = alt_sel & keep_mask;
        pd = analog_pd_en;
        pcv = pc_in;
        halt_req = (i == 4);
        stop_req = 1'b1;
        step();
        {halt_req, stop_req} = 2'h0;
        chk(48'({ctrl_init, osc_run, cpu_run, timer_run, pll_run, adc_run, pwm_run, sio_run,
          fcnt_run, tone_run}), 48'h200);
        chk(pin_alt_o, a);
        rnd();
        step();
        chk(48'(ctrl_init), 48'h0);
        chk(pin_val_o, v);
        chk(pin_dir_o, d);
        chk(48'({pc_hold, analog_pd_o}), 48'({pcv, pd}));
        stop_release = 1'b1;
        step();
        stop_release = 1'b0;
        k = 0;
        while (cpu_run !== 1'b1 && k < 200)
        begin
          step();
          k++;
        end
        chk(48'(k >= settle_n(stab_time) && k <= settle_n(stab_time) + 1), 48'h1);
      end
      else
      begin
        // Stop while the chip-enable reset is pending must do nothing
        {ce_rise, ce_cnt_busy} = 2'(i / 3 % 3 + 1);
        stop_req = 1'b1;
        step();
        {stop_req, ce_rise, ce_cnt_busy} = 3'h0;
        chk(48'({ctrl_init, osc_run, cpu_run}), 48'h3);
      end
      $display("test %0d done", i);
    end
    end_sim();
  end
endmodule
